//--- design/pmg_pkg.sv
// Shared constants, register map and mode types for the programmable macrocell group.
package pmg_pkg;

  // Structure of one logic group.
  localparam int NUM_MC = 16; // Macrocells in one logic group.
  localparam int CHAIN_LEN = 8; // Macrocells in one lending chain.
  localparam int NUM_PT = 5; // Own product terms of each macrocell.
  localparam int MAX_SETS = 3; // Parallel expander sets a macrocell may borrow.
  localparam int NUM_DED = 4; // Dedicated input pins.
  localparam int NUM_IO = 16; // I/O pins, one per macrocell.
  localparam int NUM_ROUTE = NUM_DED + NUM_IO + NUM_MC; // Signals from the routing bus.
  localparam int NUM_SIG = NUM_ROUTE + NUM_MC; // Routed signals plus shareable expanders.
  localparam int NUM_LIT = 2 * NUM_SIG; // True and complement of every array signal.

  // Dedicated input positions.
  localparam int DED_FIRST_GLOBAL_CLOCK_PIN = 0; // first_global_clock_pin.
  localparam int DED_GCLR = 1; // global_clear_pin_n.
  localparam int DED_OE1 = 2; // First output enable, active low.
  localparam int DED_SECOND_GLOBAL_CLOCK_PIN = 3; // second_global_clock_pin, doubles as second output enable.

  // Product term roles inside one macrocell.
  localparam int PT_CLR = 0; // May drive the asynchronous clear.
  localparam int PT_PRE = 1; // May drive the asynchronous preset.
  localparam int PT_CTL = 2; // May drive the clock enable or the array clock.
  localparam int PT_AUX = 3; // Second input (K or R) of JK and SR storage.
  localparam int PT_SHARE = 4; // May become the shareable expander.

  // Configuration memory layout, in 32-bit words.
  localparam int TERM_WORDS = 4; // Words holding one product term mask.
  localparam int TOP_BITS = NUM_LIT - 3 * 32; // Mask bits held in a term's last word.
  localparam int MODE_WORD = NUM_PT * TERM_WORDS; // Mode word offset inside a macrocell.
  localparam int MC_STRIDE = 32; // Words reserved per macrocell.
  localparam int CFG_DEPTH = NUM_MC * MC_STRIDE; // Total configuration words.
  localparam int CFG_IDX_W = 9; // Word index width of the configuration memory.

  // Mode word fields.
  localparam int MODE_FF_LSB = 0; // Two bits of storage type.
  localparam int MODE_BYPASS = 2; // Combinatorial output, register bypassed.
  localparam int MODE_CLK_LSB = 3; // Two bits of clock mode.
  localparam int MODE_GSEL = 5; // Selects global clock B instead of A.
  localparam int MODE_INV = 6; // XOR polarity of the sum.
  localparam int MODE_GCLR = 7; // Clear also driven by the global clear pin.
  localparam int MODE_FAST = 8; // D input taken straight from the I/O pin.
  localparam int MODE_SHARE = 9; // Term 4 offered to the shareable pool.
  localparam int MODE_SETS_LSB = 10; // Two bits: parallel expander sets borrowed.
  localparam int MODE_LEND = 12; // All five terms lent up the chain.
  localparam int MODE_CLR_PT = 13; // Term 0 steered to the clear.
  localparam int MODE_PRE_PT = 14; // Term 1 steered to the preset.
  localparam int MODE_CTL_PT = 15; // Term 2 steered to the clock enable.

  // Global clock configuration fields.
  localparam int GCLK_W = 4; // Width of the global clock configuration.
  localparam int GC_A_PIN = 0; // Clock A taken from the second pin.
  localparam int GC_A_INV = 1; // Clock A inverted.
  localparam int GC_B_PIN = 2; // Clock B taken from the second pin.
  localparam int GC_B_INV = 3; // Clock B inverted.
  localparam int CTRL_RUN = 0; // Run bit in the control register.
  localparam int ROUTE_LO_W = 32; // Routing gates held in the low word.

  // Byte addresses on the register bus.
  localparam int ADDR_W = 12; // Address width.
  localparam int REGION_BIT = 11; // Clear for the configuration memory.
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h800; // Run control.
  localparam logic [ADDR_W-1:0] ADDR_GCLK = 12'h804; // Global clock selection.
  localparam logic [ADDR_W-1:0] ADDR_ROUTE_LO = 12'h808; // Routing gates 31..0.
  localparam logic [ADDR_W-1:0] ADDR_ROUTE_HI = 12'h80c; // Routing gates 35..32.
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h810; // Outputs, read only.

  localparam logic [1:0] RESP_OKAY = 2'h0; // Bus response: done.
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Bus response: refused.

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} pmg_ff_t; // Storage types.
  typedef enum logic [1:0] {CLK_GLOBAL, CLK_GLOBAL_EN, CLK_ARRAY} pmg_clk_t; // Clock modes.

endpackage

//--- design/pmg_logic_group.sv
// One logic group of sixteen macrocells with expanders, routing gates and a register bus.
`timescale 1ns/1ps
module pmg_logic_group
  import pmg_pkg::*;
#(
  parameter bit ENHANCED = 1'b1 // Enhanced variant: second global clock and fast input path.
)
(
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low; stands for power-up.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic [2:0] s_axi_awprot, // Write protection, ignored.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic [2:0] s_axi_arprot, // Read protection, ignored.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [NUM_DED-1:0] ded_pin, // Dedicated input pins.
  input wire logic [NUM_IO-1:0] io_pin, // I/O pins used as inputs.
  output logic [NUM_MC-1:0] mc_out_q, // Macrocell outputs.
  output logic [1:0] goe_q // Global output enables, active high.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [31:0] cfg_mem [CFG_DEPTH]; // Term masks and mode words of all macrocells.
  logic run_q; // Group running; configuration frozen.
  logic [GCLK_W-1:0] gclk_cfg_q; // Global clock selection.
  logic [NUM_ROUTE-1:0] route_en_q; // Routing gate bits.
  logic [NUM_DED-1:0] ded_s1_q, ded_s2_q, ded_s3_q; // Dedicated pin synchroniser and history.
  logic [NUM_IO-1:0] io_s1_q, io_s2_q; // I/O pin synchroniser.
  logic [NUM_ROUTE-1:0] routed; // Signals let into the group.
  logic [NUM_MC-1:0] pool; // Shareable expanders.
  logic [NUM_LIT-1:0] lit; // Literals for ordinary terms.
  logic [NUM_LIT-1:0] lit_free; // Literals without the pool, for the shareable term.
  logic [NUM_MC-1:0] lend_sum; // Sum lent by each macrocell, zero if it does not lend.
  logic [NUM_MC-1:0] mc_val; // Output of each macrocell before the output flop.
  logic gclk_a_lvl, gclk_a_old, gclk_a_edge; // Global clock A.
  logic gclk_b_lvl, gclk_b_old, gclk_b_edge; // Global clock B.
  logic gclr_act; // Global clear pin asserted.
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q; // Bus handshake state.
  logic aw_got_q, w_got_q; // Write address and data held.
  logic [ADDR_W-1:0] awaddr_q; // Held write address.
  logic [31:0] wdata_q, rdata_q; // Held write data and read answer.
  logic [3:0] wstrb_q; // Held byte strobes.
  logic [1:0] bresp_q, rresp_q; // Responses.
  logic aw_fire, w_fire, ar_fire, do_write; // Bus events.
  logic wr_mc, wr_ok, rd_mc; // Write and read decode.
  logic [CFG_IDX_W-1:0] wr_idx; // Word written in configuration memory.
  logic [31:0] status_w, wr_cur, wr_merged, rd_word; // Register views.

  // Builds the word seen at a register address; unknown addresses read zero.
  function automatic logic [31:0] reg_view(input logic [ADDR_W-1:0] a, input logic run,
      input logic [GCLK_W-1:0] gc, input logic [NUM_ROUTE-1:0] re, input logic [31:0] st);
    logic [31:0] v;
    v = '0;
    case (a)
      ADDR_CTRL: v[CTRL_RUN] = run;
      ADDR_GCLK: v[GCLK_W-1:0] = gc;
      ADDR_ROUTE_LO: v = re[ROUTE_LO_W-1:0];
      ADDR_ROUTE_HI: v[NUM_ROUTE-ROUTE_LO_W-1:0] = re[NUM_ROUTE-1:ROUTE_LO_W];
      ADDR_STATUS: v = st;
      default: v = '0;
    endcase
    return v;
  endfunction

  // True for addresses that answer without error.
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return !a[REGION_BIT] || a == ADDR_CTRL || a == ADDR_GCLK || a == ADDR_ROUTE_LO ||
      a == ADDR_ROUTE_HI || a == ADDR_STATUS;
  endfunction

  // Applies byte strobes to a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
      v[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before any logic, a third only for edge history.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Dedicated pins reset high: clear and enables read idle, and no clock edge follows reset.
      ded_s1_q <= '1;
      ded_s2_q <= '1;
      ded_s3_q <= '1;
      io_s1_q <= '0;
      io_s2_q <= '0;
    end
    else
    begin
      ded_s1_q <= ded_pin;
      ded_s2_q <= ded_s1_q;
      ded_s3_q <= ded_s2_q;
      io_s1_q <= io_pin;
      io_s2_q <= io_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Global controls. A basic variant has one clock, the true first pin.
  assign gclk_a_lvl = ((ENHANCED && gclk_cfg_q[GC_A_PIN]) ? ded_s2_q[DED_SECOND_GLOBAL_CLOCK_PIN]
    : ded_s2_q[DED_FIRST_GLOBAL_CLOCK_PIN]) ^ (ENHANCED & gclk_cfg_q[GC_A_INV]);
  assign gclk_a_old = ((ENHANCED && gclk_cfg_q[GC_A_PIN]) ? ded_s3_q[DED_SECOND_GLOBAL_CLOCK_PIN]
    : ded_s3_q[DED_FIRST_GLOBAL_CLOCK_PIN]) ^ (ENHANCED & gclk_cfg_q[GC_A_INV]);
  assign gclk_b_lvl = ENHANCED ? ((gclk_cfg_q[GC_B_PIN] ? ded_s2_q[DED_SECOND_GLOBAL_CLOCK_PIN]
    : ded_s2_q[DED_FIRST_GLOBAL_CLOCK_PIN]) ^ gclk_cfg_q[GC_B_INV]) : gclk_a_lvl;
  assign gclk_b_old = ENHANCED ? ((gclk_cfg_q[GC_B_PIN] ? ded_s3_q[DED_SECOND_GLOBAL_CLOCK_PIN]
    : ded_s3_q[DED_FIRST_GLOBAL_CLOCK_PIN]) ^ gclk_cfg_q[GC_B_INV]) : gclk_a_old;
  assign gclk_a_edge = gclk_a_lvl & ~gclk_a_old;
  assign gclk_b_edge = gclk_b_lvl & ~gclk_b_old;
  assign gclr_act = ~ded_s2_q[DED_GCLR];

  ////////////////////////////////////////////////////////////////////////////////
  // Routing bus: every source enters through a two-input AND with its gate bit.
  // Macrocells feed back from their output flops, which keeps the array free of loops.
  assign routed = {mc_out_q, io_s2_q, ded_s2_q} & route_en_q;
  assign lit = {~{pool, routed}, {pool, routed}};
  assign lit_free = {{NUM_MC{1'b1}}, ~routed, {NUM_MC{1'b1}}, routed};

  ////////////////////////////////////////////////////////////////////////////////
  // Macrocells.
  for (genvar m = 0; m < NUM_MC; m++)
  begin : mc_g
    localparam int BASE = m * MC_STRIDE;
    localparam int LOC = m % CHAIN_LEN; // Position inside its chain.
    logic [31:0] mode; // Mode word.
    logic [NUM_PT-1:0] pt; // Own product terms.
    logic [NUM_PT-1:0] own_sel; // Terms that reach the own OR.
    logic [MAX_SETS-1:0] set_hit; // Borrowed sets.
    pmg_ff_t ff; // Storage type.
    pmg_clk_t cm; // Clock mode.
    logic sum, xo, d_in, clr, pre, g_edge, clk_ev, q_d, q_q, ctl_old_q;

    assign mode = cfg_mem[BASE + MODE_WORD];
    assign ff = pmg_ff_t'(mode[MODE_FF_LSB +: 2]);
    assign cm = pmg_clk_t'(mode[MODE_CLK_LSB +: 2]);

    // Each term is the AND of the literals its mask selects; the shareable one
    // sees no pool literal, so no term can feed itself.
    for (genvar t = 0; t < NUM_PT; t++)
    begin : pt_g
      localparam int A = BASE + t * TERM_WORDS;
      logic [NUM_LIT-1:0] mask;
      assign mask = {cfg_mem[A+3][TOP_BITS-1:0], cfg_mem[A+2], cfg_mem[A+1], cfg_mem[A]};
      assign pt[t] = &(~mask | ((t == PT_SHARE) ? lit_free : lit));
    end

    assign pool[m] = mode[MODE_SHARE] & ~pt[PT_SHARE];

    // Steered terms leave the sum; a lender gives all five away.
    assign own_sel = {~mode[MODE_SHARE], ~(ff == FF_JK || ff == FF_SR),
      ~(mode[MODE_CTL_PT] || cm == CLK_ARRAY), ~mode[MODE_PRE_PT], ~mode[MODE_CLR_PT]};
    assign lend_sum[m] = mode[MODE_LEND] & (LOC != CHAIN_LEN - 1) & (|pt);

    // Set j comes from the macrocell j+1 below; none past the chain's bottom.
    for (genvar j = 0; j < MAX_SETS; j++)
    begin : set_g
      if (j < LOC)
      begin : hit_g
        assign set_hit[j] = (mode[MODE_SETS_LSB +: 2] > 2'(j)) & lend_sum[m-1-j];
      end
      else
      begin : none_g
        assign set_hit[j] = 1'b0;
      end
    end

    assign sum = (~(mode[MODE_LEND] & (LOC != CHAIN_LEN - 1)) & |(pt & own_sel))
      | (|set_hit);
    assign xo = sum ^ mode[MODE_INV];
    assign d_in = (ENHANCED && mode[MODE_FAST]) ? io_s2_q[m] : xo;
    assign clr = (mode[MODE_CLR_PT] & pt[PT_CLR]) | (mode[MODE_GCLR] & gclr_act);
    assign pre = mode[MODE_PRE_PT] & pt[PT_PRE];
    assign g_edge = mode[MODE_GSEL] ? gclk_b_edge : gclk_a_edge;

    // Clock event for the selected mode; the unused fourth code never clocks.
    always_comb
    begin
      case (cm)
        CLK_GLOBAL: clk_ev = g_edge;
        CLK_GLOBAL_EN: clk_ev = g_edge & (~mode[MODE_CTL_PT] | pt[PT_CTL]);
        CLK_ARRAY: clk_ev = pt[PT_CTL] & ~ctl_old_q;
        default: clk_ev = 1'b0;
      endcase
    end

    // Next state by storage type; JK and SR take K or R from term 3, SR set wins.
    always_comb
    begin
      unique case (ff)
        FF_D: q_d = d_in;
        FF_T: q_d = q_q ^ d_in;
        FF_JK: q_d = (d_in & ~q_q) | (~pt[PT_AUX] & q_q);
        FF_SR: q_d = d_in | (~pt[PT_AUX] & q_q);
      endcase
    end

    // The register: clear beats preset, both beat the clock, all act each cycle.
    always_ff @(posedge aclk)
    begin
      if (!aresetn || !run_q)
      begin
        q_q <= 1'b0;
        ctl_old_q <= 1'b0;
      end
      else
      begin
        ctl_old_q <= pt[PT_CTL];
        if (clr)
          q_q <= 1'b0;
        else if (pre)
          q_q <= 1'b1;
        else if (clk_ev)
          q_q <= q_d;
      end
    end

    assign mc_val[m] = mode[MODE_BYPASS] ? xo : q_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output flops; a bypassed macrocell therefore shows one cycle later.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mc_out_q <= '0;
      goe_q <= '0;
    end
    else
    begin
      mc_out_q <= run_q ? mc_val : '0;
      goe_q <= ~{ded_s2_q[DED_SECOND_GLOBAL_CLOCK_PIN], ded_s2_q[DED_OE1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode.
  assign aw_fire = s_axi_awvalid & awready_q;
  assign w_fire = s_axi_wvalid & wready_q;
  assign ar_fire = s_axi_arvalid & arready_q;
  assign do_write = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_mc = ~awaddr_q[REGION_BIT];
  assign wr_idx = awaddr_q[CFG_IDX_W+1:2];
  assign status_w = 32'({goe_q, mc_out_q});
  // Only the run bit may change while running; status is read only.
  assign wr_ok = addr_known(awaddr_q) && awaddr_q != ADDR_STATUS
    && (!run_q || awaddr_q == ADDR_CTRL);
  assign wr_cur = wr_mc ? cfg_mem[wr_idx]
    : reg_view(awaddr_q, run_q, gclk_cfg_q, route_en_q, status_w);
  assign wr_merged = merge(wr_cur, wdata_q, wstrb_q);
  assign rd_mc = ~s_axi_araddr[REGION_BIT];
  assign rd_word = rd_mc ? cfg_mem[s_axi_araddr[CFG_IDX_W+1:2]]
    : reg_view(s_axi_araddr, run_q, gclk_cfg_q, route_en_q, status_w);

  // Bus handshakes: one write and one read at a time, address and data in any order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {awready_q, wready_q, arready_q, bvalid_q, rvalid_q} <= '0;
      {aw_got_q, w_got_q} <= '0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      rdata_q <= '0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      awready_q <= ~(aw_got_q | aw_fire | bvalid_q | do_write);
      wready_q <= ~(w_got_q | w_fire | bvalid_q | do_write);
      arready_q <= ~(rvalid_q | ar_fire);
      if (aw_fire)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        {aw_got_q, w_got_q} <= '0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (ar_fire)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // Configuration store: written only while stopped, so it stays static in use.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q <= 1'b0;
      gclk_cfg_q <= '0;
      route_en_q <= '0;
      for (int i = 0; i < CFG_DEPTH; i++)
        cfg_mem[i] <= '0;
    end
    else if (do_write && wr_ok)
    begin
      if (wr_mc)
        cfg_mem[wr_idx] <= wr_merged;
      else if (awaddr_q == ADDR_CTRL)
        run_q <= wr_merged[CTRL_RUN];
      else if (awaddr_q == ADDR_GCLK)
        gclk_cfg_q <= wr_merged[GCLK_W-1:0];
      else if (awaddr_q == ADDR_ROUTE_LO)
        route_en_q[ROUTE_LO_W-1:0] <= wr_merged;
      else
        route_en_q[NUM_ROUTE-1:ROUTE_LO_W] <= wr_merged[NUM_ROUTE-ROUTE_LO_W-1:0];
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ce_off;
    run_q && mc_g[2].cm == CLK_GLOBAL_EN && mc_g[2].mode[MODE_CTL_PT]
      && !mc_g[2].pt[PT_CTL] && !mc_g[2].clr && !mc_g[2].pre;
  endsequence
  sequence s_array_rise;
    run_q && mc_g[4].cm == CLK_ARRAY && !mc_g[4].pt[PT_CTL]
      ##1 run_q && mc_g[4].pt[PT_CTL] && !mc_g[4].clr && !mc_g[4].pre;
  endsequence
  sequence s_gclk_rise;
    !gclk_a_lvl ##1 gclk_a_lvl;
  endsequence

  a_powerup_zero:
    assert property ($rose(aresetn) |-> mc_out_q == '0 && !mc_g[0].q_q)
    else $error("Macrocell state not zero after reset.");
  a_cfg_frozen:
    assert property (do_write && run_q && awaddr_q != ADDR_CTRL
      |=> bvalid_q && bresp_q == RESP_SLVERR && $stable(cfg_mem[0]))
    else $error("Configuration write accepted while running.");
  a_gclr_clear:
    assert property (run_q && mc_g[1].mode[MODE_GCLR] && !ded_s2_q[DED_GCLR] |=> !mc_g[1].q_q)
    else $error("Global clear pin did not clear the register.");
  a_preset_set:
    assert property (run_q && mc_g[5].pre && !mc_g[5].clr |=> mc_g[5].q_q ##1 mc_out_q[5]
      || mc_g[5].mode[MODE_BYPASS] || !run_q)
    else $error("Preset term did not set the register.");
  a_route_gate:
    assert property (route_en_q == '0 |-> routed == '0)
    else $error("Ungated signal entered the group.");
  a_chain_ends:
    assert property (mc_g[0].set_hit == '0 && mc_g[CHAIN_LEN].set_hit == '0
      && !lend_sum[CHAIN_LEN-1] && !lend_sum[NUM_MC-1])
    else $error("Chain end borrowed or lent.");
  a_enable_hold:
    assert property (s_ce_off |=> $stable(mc_g[2].q_q))
    else $error("Register changed with clock enable low.");
  a_array_clock:
    assert property (s_array_rise |=> mc_g[4].q_q == $past(mc_g[4].q_d))
    else $error("Array clock edge did not load the register.");
  a_bypass_path:
    assert property (run_q && mc_g[0].mode[MODE_BYPASS] |=> mc_out_q[0] == $past(mc_g[0].xo))
    else $error("Bypassed macrocell output wrong.");
  a_gclk_edge:
    assert property (s_gclk_rise |-> gclk_a_edge)
    else $error("Global clock edge missed.");

endmodule // pmg_logic_group

//--- bench/pmg_pin_model.sv
// Board-side driver of the dedicated and I/O pins of the macrocell group.
`timescale 1ns/1ps
module pmg_pin_model
  import pmg_pkg::*;
(
  input wire logic aclk, // System clock.
  input wire logic [19:0] pin_set, // Wanted levels: I/O pins above, dedicated in 3..0.
  output logic [NUM_DED-1:0] ded_pin, // Dedicated pins.
  output logic [NUM_IO-1:0] io_pin // I/O pins, used as inputs here.
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pins settle to the idle board levels at time zero.
  initial {io_pin, ded_pin} = 20'h6;
  // Pins move one clock after the bench asks, on the same rising edge that the group samples them on.
  always @(posedge aclk)
  begin
    {io_pin, ded_pin} <= pin_set;
  end
endmodule // pmg_pin_model

//--- bench/pmg_logic_group_tb.sv
// Self-checking bench for the macrocell group over its register bus and pins.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pmg_logic_group_tb
  import pmg_pkg::*;
;
  logic aclk = 1'h0; // System clock.
  logic aresetn = 1'h0; // Reset, active low.
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0; // Bus addresses.
  logic [31:0] s_axi_wdata = '0; // Write data.
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0; // Write requests.
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0; // Read requests.
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // Answers.
  logic [1:0] s_axi_bresp, s_axi_rresp, goe_q, r; // Responses and enables.
  logic [31:0] s_axi_rdata, d; // Read data.
  logic [NUM_DED-1:0] ded_pin; // Dedicated pins.
  logic [NUM_IO-1:0] io_pin; // I/O pins.
  logic [15:0] mc_out_q; // Macrocell outputs.
  logic [19:0] pin_set = 20'h6; // Clear pin high, first enable off, clock low.
  int error_cnt = 0, num_checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  pmg_pin_model u_pins (.aclk, .pin_set, .ded_pin, .io_pin);
  pmg_logic_group u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ded_pin, .io_pin,
    .mc_out_q, .goe_q);
  always #20 aclk = ~aclk;
  // A hung handshake is cut short well beyond the hundred or so cycles the tests need.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Write: address and data held until each is taken, then wait for the response.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, output logic [1:0] rsp);
    bit dn;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      rsp = s_axi_bresp;
      dn = s_axi_bvalid;
    end while (!dn);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  // Read: address held until taken, data captured at the edge that shows rvalid.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] rsp);
    bit dn;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      dn = s_axi_rvalid;
    end while (!dn);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(ADDR_CTRL, d, r);
    `CHK(d, 32'h0)
    rd(ADDR_STATUS, d, r);
    `CHK(d & 32'hffff, 32'h0)
    $display("test reset done");
    wr(12'h050, 32'h4, r); // Macrocell 0 bypassed, its empty terms sum to one.
    `CHK(r, RESP_OKAY)
    wr(12'h0d0, 32'h80, r); // Macrocell 1 also cleared by the global clear pin.
    wr(12'h120, 32'h2, r); // Macrocell 2 enable term reads the global clear pin, whose routing gate stays shut.
    wr(12'h150, 32'h8008, r); // Macrocell 2 on the global clock with that enable.
    wr(12'h220, 32'h1, r); // Macrocell 4 array clock follows the first clock pin.
    wr(12'h250, 32'h10, r); // Macrocell 4 in array clock mode.
    wr(12'h2d0, 32'h4000, r); // Macrocell 5 held set by its always-true preset term.
    wr(ADDR_ROUTE_LO, 32'h1, r); // Only the first clock pin enters the group.
    rd(12'h150, d, r);
    `CHK({d, r}, {32'h8008, RESP_OKAY})
    wr(ADDR_CTRL, 32'h1, r);
    wr(12'h050, 32'h0, r); // Configuration is frozen while running.
    `CHK(r, RESP_SLVERR)
    wr(ADDR_STATUS, 32'h0, r);
    `CHK(r, RESP_SLVERR)
    rd(12'h814, d, r);
    `CHK({d, r}, {32'h0, RESP_SLVERR})
    $display("test bus done");
    repeat (6) @(posedge aclk);
    rd(ADDR_STATUS, d, r);
    `CHK(d, 32'h20021)
    pin_set[0] <= 1'h1;
    repeat (6) @(posedge aclk);
    rd(ADDR_STATUS, d, r);
    `CHK(d, 32'h2fffb)
    pin_set[1] <= 1'h0;
    repeat (6) @(posedge aclk);
    rd(ADDR_STATUS, d, r);
    `CHK(d, 32'h2fff9)
    `CHK(mc_out_q, 16'hfff9)
    `CHK(goe_q, 2'h2)
    $display("test pins done");
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(ADDR_STATUS, d, r);
    `CHK(d & 32'hffff, 32'h0)
    $display("test second reset done");
    close_out();
  end
endmodule // pmg_logic_group_tb
